// ==== inc/rca_pkg.sv ====
// Purpose: types of the rc-oscillation counting converter.
// Assumes: nothing beyond the register header.
// Notes:   constants live in rca_regs.svh.
package rca_pkg;

    // conversion sequence: idle, arming the run signal, counting
    typedef enum logic [1:0] {
        RCA_IDLE,
        RCA_ARM,
        RCA_RUN
    } rca_state_t;

endpackage

// ==== inc/rca_regs.svh ====
// Purpose: offsets, field positions, reset values and limits of the
//          rc-oscillation counting converter.
// Assumes: plain register port, one register per address.
// Notes:   definitions only.
`ifndef RCA_REGS_SVH
`define RCA_REGS_SVH

// register port shape
`define RCA_ADDR_W          4
`define RCA_DATA_W          32

// register offsets
`define RCA_OFF_CTRL_FIRST  4'h0
`define RCA_OFF_CTRL_SECOND 4'h1
`define RCA_OFF_SYS_COUNT   4'h2
`define RCA_OFF_OSC_COUNT   4'h3
`define RCA_OFF_STATUS      4'h4

// first control register fields
`define RCA_ENABLE_BIT      0
`define RCA_REF_SEL_BIT     1

// second control register field
`define RCA_MODE_W          4
`define RCA_MODE_RST        4'h0
`define RCA_MODE_EXT_ZERO   4'h0
`define RCA_MODE_EXT_ONE    4'h7

// decade system-clock counter: five bcd digits, top digit 0..7
`define RCA_SYS_DIGITS      5
`define RCA_SYS_W           20
`define RCA_SYS_RST         20'h0_0000
`define RCA_DIGIT_MAX       4'h9
`define RCA_TOP_DIGIT_MAX   4'h7
`define RCA_SYS_MAX         20'h7_9999

// 14-stage binary oscillation counter
`define RCA_OSC_W           14
`define RCA_OSC_RST         14'h0000
`define RCA_OSC_MAX         14'h3fff

// oscillator pin indices
`define RCA_PINS            6
`define RCA_PIN_RS0         0
`define RCA_PIN_RT0         1
`define RCA_PIN_RS01        2
`define RCA_PIN_CS0         3
`define RCA_PIN_RS1         4
`define RCA_PIN_RT1         5

`endif

// ==== src/rca_counting_adc.sv ====
// Purpose: counting logic of a two-channel rc-oscillation converter.
// Assumes: sys_clk 200 MHz; rc and external clocks are asynchronous.
// Notes:   the run signal rises two cycles after enable, through the arm state.
`timescale 1ns/100ps
`include "rca_regs.svh"

// Notes on behaviour
// RL1: external modes float oscillator pins and count the external clock.
// RL2: at most one oscillator circuit is ever driven.
// RL3: codes 1..6 pick the documented resistor and capacitor pin pairs; codes 5 and 6 drive a single resistor pin only.
// RL4: reference bit 0: system counter gates, oscillation counter results.
// RL5: reference bit 1: oscillation counter gates, system counter results.
// RL6: software preloads system counter with 80,000 minus gate count.
// RL7: software clears oscillation counter before a system-gated run.
// RL8: software writes 1 to first control to start system-gated run.
// RL9: run signal rises after enable; counting waits for run.
// RL10: system counter overflow clears enable, stops, raises request.
// RL11: system-gated: oscillation counted from run rise until overflow.
// RL12: software preloads oscillation counter with 4000H minus gate.
// RL13: software clears system counter before an oscillation-gated run.
// RL14: software writes 3 to first control for oscillation-gated run.
// RL15: oscillation-gated: oscillation counter counts once run is high.
// RL16: oscillation counter overflow clears enable, ends, raises request.
// RL17: oscillation-gated: system clocks counted from run rise to end.
// RL18: preload, clear and mode select may come in any order first.
// RL19: decade counter tops at 79,999; binary counter tops at 16,383.
// RL20: reference bit 1, enable bit 0; clear enable halts all counting.
// RL21: mode is bits 3..0; 0 and 7 external; bit 3 set floats pins.
module rca_counting_adc (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic [`RCA_ADDR_W-1:0] reg_addr,
    input  wire logic [`RCA_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`RCA_DATA_W-1:0] reg_rdata,
    input  wire logic                   rc_oscillation_clock,
    input  wire logic                   external_clock_input_zero,
    input  wire logic                   external_clock_input_one,
    output logic      [`RCA_PINS-1:0]   osc_pin_out,
    output logic      [`RCA_PINS-1:0]   osc_pin_oe,
    output logic                        synchronized_run_signal,
    output logic                        converter_interrupt_request
);
    logic                   conversion_enable_bit_ff;
    logic                   reference_select_bit_ff;
    logic [`RCA_MODE_W-1:0] oscillator_mode_field_ff;
    logic [`RCA_SYS_W-1:0]  system_clock_counter_ff;
    logic [`RCA_OSC_W-1:0]  oscillation_counter_ff;
    rca_pkg::rca_state_t    state_ff;
    rca_pkg::rca_state_t    nxt_state;
    logic                   run_ff;
    logic                   irq_ff;
    logic [`RCA_DATA_W-1:0] rdata_ff;
    logic [`RCA_PINS-1:0]   pin_out_ff;
    logic [`RCA_PINS-1:0]   pin_oe_ff;
    logic                   clk_prev_ff;

    logic [2:0]             clk_sync;
    logic                   count_src;
    logic                   osc_edge;
    logic                   wr_first;
    logic                   wr_second;
    logic                   wr_sys;
    logic                   wr_osc;
    logic                   counting;
    logic                   sys_at_max;
    logic                   osc_at_max;
    logic                   osc_step;
    logic                   gate_done;
    logic [`RCA_SYS_W-1:0]  sys_inc;
    logic [`RCA_SYS_DIGITS:0] carry;
    logic [`RCA_PINS-1:0]   dec_out;
    logic [`RCA_PINS-1:0]   dec_oe;

    // register port decode
    assign wr_first  = reg_wr && (reg_addr == `RCA_OFF_CTRL_FIRST);
    assign wr_second = reg_wr && (reg_addr == `RCA_OFF_CTRL_SECOND);
    assign wr_sys    = reg_wr && (reg_addr == `RCA_OFF_SYS_COUNT);
    assign wr_osc    = reg_wr && (reg_addr == `RCA_OFF_OSC_COUNT);

    // rc clock and both external clocks come from pins
    rca_sync2 #(
        .W (3)
    ) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in ({external_clock_input_one,
                    external_clock_input_zero,
                    rc_oscillation_clock}),
        .sync_out (clk_sync)
    );

    // external codes count a pin clock instead of the oscillator
    always_comb begin
        case (oscillator_mode_field_ff)
            `RCA_MODE_EXT_ZERO: count_src = clk_sync[1]; // RL1
            `RCA_MODE_EXT_ONE:  count_src = clk_sync[2]; // RL1
            default:            count_src = clk_sync[0];
        endcase
    end

    // rising edge of the selected, already synchronised clock
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_prev_ff <= 1'b0;
        end else begin
            clk_prev_ff <= count_src;
        end
    end
    assign osc_edge = count_src && !clk_prev_ff;

    // counting needs both enable and the run signal
    assign counting   = run_ff && conversion_enable_bit_ff; // RL9 RL20
    assign sys_at_max = (system_clock_counter_ff == `RCA_SYS_MAX); // RL19
    assign osc_at_max = (oscillation_counter_ff == `RCA_OSC_MAX); // RL19
    assign osc_step   = counting && osc_edge;

    // gate end: overflow of whichever counter the reference bit picks
    assign gate_done = counting &&
                       (reference_select_bit_ff ?
                        (osc_step && osc_at_max) :  // RL16
                        sys_at_max);                // RL10

    // bcd increment, top digit wraps after 7
    assign carry[0] = 1'b1;
    for (genvar g = 0; g < `RCA_SYS_DIGITS; g++) begin : g_digit
        logic [3:0] dig;
        logic [3:0] lim;
        assign dig = system_clock_counter_ff[4*g +: 4];
        assign lim = (g == `RCA_SYS_DIGITS - 1) ? `RCA_TOP_DIGIT_MAX
                                                : `RCA_DIGIT_MAX;
        assign carry[g+1] = carry[g] && (dig == lim);
        assign sys_inc[4*g +: 4] = !carry[g]   ? dig :
                                   (dig == lim) ? 4'h0 : dig + 4'h1; // RL19
    end

    // first control: software write wins over the overflow clear,
    // since the write carries the newer intent
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            conversion_enable_bit_ff <= 1'b0;
            reference_select_bit_ff  <= 1'b0;
        end else if (wr_first) begin
            conversion_enable_bit_ff <= reg_wdata[`RCA_ENABLE_BIT];  // RL20
            reference_select_bit_ff  <= reg_wdata[`RCA_REF_SEL_BIT]; // RL20
        end else if (gate_done) begin
            conversion_enable_bit_ff <= 1'b0; // RL10 RL16
        end
    end

    // second control: mode code, may be set in any order before start
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oscillator_mode_field_ff <= `RCA_MODE_RST;
        end else if (wr_second) begin
            oscillator_mode_field_ff <= reg_wdata[`RCA_MODE_W-1:0]; // RL21
        end
    end

    // sequence: enable seen, then run raised one edge later
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rca_pkg::RCA_IDLE: begin
                if (conversion_enable_bit_ff) begin
                    nxt_state = rca_pkg::RCA_ARM;
                end
            end
            rca_pkg::RCA_ARM: begin
                nxt_state = conversion_enable_bit_ff ? rca_pkg::RCA_RUN
                                                     : rca_pkg::RCA_IDLE;
            end
            rca_pkg::RCA_RUN: begin
                if (!conversion_enable_bit_ff) begin
                    nxt_state = rca_pkg::RCA_IDLE;
                end
            end
            default: nxt_state = rca_pkg::RCA_IDLE;
        endcase
    end

    // run signal is registered so counting starts on a clean edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= rca_pkg::RCA_IDLE;
            run_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            run_ff   <= (nxt_state == rca_pkg::RCA_RUN); // RL9
        end
    end

    // system counter: counts every clock while running in both modes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            system_clock_counter_ff <= `RCA_SYS_RST;
        end else if (wr_sys) begin
            system_clock_counter_ff <= reg_wdata[`RCA_SYS_W-1:0];
        end else if (counting) begin
            system_clock_counter_ff <= sys_inc; // RL4 RL17
        end
    end

    // oscillation counter: counts selected clock edges while running
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oscillation_counter_ff <= `RCA_OSC_RST;
        end else if (wr_osc) begin
            oscillation_counter_ff <= reg_wdata[`RCA_OSC_W-1:0];
        end else if (osc_step) begin
            oscillation_counter_ff <= oscillation_counter_ff + 14'h0001;
            // RL5 RL11 RL15
        end
    end

    // request pulse in the same event as the hardware enable clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= gate_done; // RL10 RL16
        end
    end

    // pin drive only while counting, so a clear halts oscillation
    rca_osc_pins u_pins (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .mode    (oscillator_mode_field_ff),
        .active  (counting),
        .phase   (clk_sync[0]),
        .pin_out (dec_out),
        .pin_oe  (dec_oe)
    );

    // pins registered for clean outputs; one cycle of lag is harmless
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out_ff <= '0;
            pin_oe_ff  <= '0;
        end else begin
            pin_out_ff <= dec_out; // RL2
            pin_oe_ff  <= dec_oe;  // RL1
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    `RCA_OFF_CTRL_FIRST: begin
                        rdata_ff[`RCA_ENABLE_BIT]  <=
                            conversion_enable_bit_ff;
                        rdata_ff[`RCA_REF_SEL_BIT] <=
                            reference_select_bit_ff;
                    end
                    `RCA_OFF_CTRL_SECOND:
                        rdata_ff[`RCA_MODE_W-1:0] <= oscillator_mode_field_ff;
                    `RCA_OFF_SYS_COUNT:
                        rdata_ff[`RCA_SYS_W-1:0] <= system_clock_counter_ff;
                    `RCA_OFF_OSC_COUNT:
                        rdata_ff[`RCA_OSC_W-1:0] <= oscillation_counter_ff;
                    `RCA_OFF_STATUS:
                        rdata_ff[0] <= run_ff;
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end

    assign reg_rdata                   = rdata_ff;
    assign osc_pin_out                 = pin_out_ff;
    assign osc_pin_oe                  = pin_oe_ff;
    assign synchronized_run_signal     = run_ff;
    assign converter_interrupt_request = irq_ff;

    // run rises exactly two edges after enable rises from idle
    property p_run_after_enable;
        @(posedge sys_clk) disable iff (!resetn)
        ($rose(conversion_enable_bit_ff) && state_ff == rca_pkg::RCA_IDLE
         && !wr_first) |=> !run_ff ##1 (run_ff || !conversion_enable_bit_ff);
    endproperty
    a_run_after_enable: assert property (p_run_after_enable) // RL9
        else $error("run signal did not follow enable");

    // no counting before run
    property p_hold_without_run;
        @(posedge sys_clk) disable iff (!resetn)
        (!run_ff && !wr_sys) |=> $stable(system_clock_counter_ff);
    endproperty
    a_hold_without_run: assert property (p_hold_without_run) // RL9
        else $error("system counter moved without run");

    // system-gated overflow ends the run and raises one request
    property p_sys_overflow;
        @(posedge sys_clk) disable iff (!resetn)
        (counting && !reference_select_bit_ff && sys_at_max && !wr_first)
        |=> (!conversion_enable_bit_ff && converter_interrupt_request &&
             system_clock_counter_ff == 20'h0_0000)
            ##1 !converter_interrupt_request;
    endproperty
    a_sys_overflow: assert property (p_sys_overflow) // RL10
        else $error("system counter overflow not handled");

    // oscillation-gated overflow ends the run and raises the request
    property p_osc_overflow;
        @(posedge sys_clk) disable iff (!resetn)
        (osc_step && reference_select_bit_ff && osc_at_max && !wr_first)
        |=> (!conversion_enable_bit_ff && converter_interrupt_request &&
             oscillation_counter_ff == 14'h0000);
    endproperty
    a_osc_overflow: assert property (p_osc_overflow) // RL16
        else $error("oscillation counter overflow not handled");

    // in system-gated mode no request without system overflow
    property p_sys_gate_only;
        @(posedge sys_clk) disable iff (!resetn)
        (converter_interrupt_request && !$past(reference_select_bit_ff))
        |-> $past(system_clock_counter_ff) == `RCA_SYS_MAX;
    endproperty
    a_sys_gate_only: assert property (p_sys_gate_only) // RL4
        else $error("request without system counter overflow");

    // oscillation edges are counted one each while running
    property p_osc_counts;
        @(posedge sys_clk) disable iff (!resetn)
        (osc_step && !wr_osc && !osc_at_max) |=>
            oscillation_counter_ff == $past(oscillation_counter_ff) + 14'h1;
    endproperty
    a_osc_counts: assert property (p_osc_counts) // RL11
        else $error("oscillation edge not counted");

    // decade carry: 0_9999 steps to 1_0000
    property p_decade_carry;
        @(posedge sys_clk) disable iff (!resetn)
        (counting && !wr_sys && system_clock_counter_ff == 20'h0_9999)
        |=> system_clock_counter_ff == 20'h1_0000;
    endproperty
    a_decade_carry: assert property (p_decade_carry) // RL17
        else $error("decade carry wrong");

    // counter never leaves the decade range when counting from valid
    property p_decade_range;
        @(posedge sys_clk) disable iff (!resetn)
        (counting && !wr_sys && system_clock_counter_ff <= `RCA_SYS_MAX &&
         system_clock_counter_ff[3:0] <= 4'h9)
        |=> system_clock_counter_ff <= `RCA_SYS_MAX;
    endproperty
    a_decade_range: assert property (p_decade_range) // RL19
        else $error("decade counter out of range");
endmodule // rca_counting_adc

// ==== src/rca_osc_pins.sv ====
// Purpose: oscillator pin drive decode per oscillation mode code.
// Assumes: mode and phase come from registers on sys_clk.
// Notes:   resistor pins drive phase, capacitor pins its inverse.
`timescale 1ns/100ps
`include "rca_regs.svh"
module rca_osc_pins (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic [`RCA_MODE_W-1:0] mode,
    input  wire logic                   active,
    input  wire logic                   phase,
    output logic      [`RCA_PINS-1:0]   pin_out,
    output logic      [`RCA_PINS-1:0]   pin_oe
);
    // one pair of pins per code 1..4, one pin for codes 5 and 6, the rest float; halted means all float
    always_comb begin
        pin_oe  = '0;
        pin_out = '0;
        if (active) begin
            case (mode)
                4'h1: begin
                    pin_oe[`RCA_PIN_RS0] = 1'b1; // RL3
                    pin_oe[`RCA_PIN_CS0] = 1'b1;
                end
                4'h2: begin
                    pin_oe[`RCA_PIN_RT0] = 1'b1; // RL3
                    pin_oe[`RCA_PIN_CS0] = 1'b1;
                end
                4'h3: begin
                    pin_oe[`RCA_PIN_RS01] = 1'b1; // RL3
                    pin_oe[`RCA_PIN_CS0]  = 1'b1;
                end
                4'h4: begin
                    pin_oe[`RCA_PIN_RS0]  = 1'b1; // RL3
                    pin_oe[`RCA_PIN_RS01] = 1'b1;
                end
                4'h5: pin_oe[`RCA_PIN_RS1] = 1'b1; // RL3
                4'h6: pin_oe[`RCA_PIN_RT1] = 1'b1; // RL3
                // external-input codes and bit 3 set: all float
                default: pin_oe = '0; // RL1 RL21
            endcase
            // capacitor side in antiphase; code 4 uses RS01 as capacitor
            pin_out = {`RCA_PINS{phase}} & pin_oe;
            pin_out[`RCA_PIN_CS0] = ~phase & pin_oe[`RCA_PIN_CS0];
            if (mode == 4'h4) begin
                pin_out[`RCA_PIN_RS01] = ~phase & pin_oe[`RCA_PIN_RS01];
            end
        end
    end

    // never both circuits at once
    property p_one_circuit;
        @(posedge sys_clk) disable iff (!resetn)
        !((|pin_oe[`RCA_PIN_CS0:`RCA_PIN_RS0]) &&
          (|pin_oe[`RCA_PIN_RT1:`RCA_PIN_RS1]));
    endproperty
    a_one_circuit: assert property (p_one_circuit) // RL2
        else $error("both oscillator circuits driven");

    // external and reserved codes float every pin
    property p_ext_float;
        @(posedge sys_clk) disable iff (!resetn)
        (mode == `RCA_MODE_EXT_ZERO || mode == `RCA_MODE_EXT_ONE ||
         mode[3]) |-> (pin_oe == '0);
    endproperty
    a_ext_float: assert property (p_ext_float) // RL21
        else $error("pins driven in external or reserved mode");
endmodule // rca_osc_pins

// ==== src/rca_sync2.sv ====
// Purpose: two-flop synchroniser for pin-side clock inputs.
// Assumes: inputs are asynchronous levels.
// Notes:   first stage is read by the second stage only.
`timescale 1ns/100ps
module rca_sync2 #(
    parameter int W = 3
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // two stages, no logic between them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // rca_sync2

// ==== testbench/rca_rc_net.sv ====
// Purpose: rc network on the oscillator pins, feeding the rc clock.
// Assumes: any driven oscillator pin closes the rc loop.
// Notes:   clock stands low while every pin floats, a dead loop.
`timescale 1ns/100ps
`include "rca_regs.svh"
module rca_rc_net #(
    parameter int HALF_NS = 20
) (
    input  wire logic [`RCA_PINS-1:0] osc_pin_oe,
    input  wire logic [`RCA_PINS-1:0] osc_pin_out,
    output logic                      rc_oscillation_clock
);
    // oscillate only while the device closes the loop
    initial begin
        rc_oscillation_clock = 1'b0;
        forever begin
            #(HALF_NS);
            if (|osc_pin_oe) rc_oscillation_clock = ~rc_oscillation_clock;
            else rc_oscillation_clock = 1'b0;
        end
    end
endmodule // rca_rc_net

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the counting converter.
// Assumes: 200 MHz sys_clk, rc network model on the pins.
// Notes:   gate counts are exact, result counts are ranges.
`timescale 1ns/100ps
`include "rca_regs.svh"
`define CHK(nm,e,a) begin check_count++; if ((a) !== (e)) begin \
    err_count++; $display("wrong value %s exp %0h got %0h", nm, e, a); \
    end end
module testbench;
    logic        sys_clk, resetn, reg_wr, reg_rd, ext0, ext1;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [5:0]  pin_out, pin_oe;
    logic        osc_clk, run, irq;
    int          err_count, check_count, n, ext_sel;
    // expected pin enables per mode code, idle codes float all
    logic [5:0]  oe_exp [16] = '{1:6'h09, 2:6'h0a, 3:6'h0c, 4:6'h05,
                                 5:6'h10, 6:6'h20, default:6'h00};

    rca_counting_adc dut (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rc_oscillation_clock(osc_clk),
        .external_clock_input_zero(ext0),
        .external_clock_input_one(ext1), .osc_pin_out(pin_out),
        .osc_pin_oe(pin_oe), .synchronized_run_signal(run),
        .converter_interrupt_request(irq));
    rca_rc_net net (.osc_pin_oe(pin_oe), .osc_pin_out(pin_out),
        .rc_oscillation_clock(osc_clk));

    // clocks: system clock and gated external test clocks
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        ext0 = 1'b0;
        ext1 = 1'b0;
        forever #25 begin
            if (ext_sel == 1) ext0 = ~ext0;
            if (ext_sel == 2) ext1 = ~ext1;
        end
    end

    task automatic end_sim;
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // bus cycles, strobes held one cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // start with ctl and time the gate up to the interrupt pulse
    task automatic conv(input logic [31:0] ctl);
        wr(`RCA_OFF_CTRL_FIRST, ctl);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        `CHK("irq seen", 1'b1, irq)
        @(posedge sys_clk);
        #1 `CHK("irq pulse", 1'b0, irq)
    endtask

    task automatic t_reset;
        rd(`RCA_OFF_CTRL_FIRST);
        `CHK("ctrl first", 32'h0000_0000, v)
        rd(4'hf);
        `CHK("unmapped", 32'h0000_0000, v)
    endtask

    // system-gated run of 200 clocks; two run-latency edges before them
    task automatic t_ref0;
        wr(`RCA_OFF_SYS_COUNT, 32'h0007_9800);
        wr(`RCA_OFF_OSC_COUNT, 32'h0000_0000);
        wr(`RCA_OFF_CTRL_SECOND, 32'h0000_0001);
        conv(32'h0000_0001);
        `CHK("gate cycles", 202, n)
        rd(`RCA_OFF_CTRL_FIRST);
        `CHK("enable", 32'h0000_0000, v)
        rd(`RCA_OFF_SYS_COUNT);
        `CHK("sys wrap", 32'h0000_0000, v)
        rd(`RCA_OFF_OSC_COUNT);
        `CHK("osc count", 1'b1, v >= 20 && v <= 27)
    endtask

    // oscillation-gated run of 16 rc periods, other setup order
    task automatic t_ref1;
        wr(`RCA_OFF_CTRL_SECOND, 32'h0000_0002);
        wr(`RCA_OFF_SYS_COUNT, 32'h0000_0000);
        wr(`RCA_OFF_OSC_COUNT, 32'h0000_3ff0);
        conv(32'h0000_0003);
        rd(`RCA_OFF_CTRL_FIRST);
        `CHK("ref kept", 32'h0000_0002, v)
        rd(`RCA_OFF_OSC_COUNT);
        `CHK("osc wrap", 32'h0000_0000, v)
        rd(`RCA_OFF_SYS_COUNT);
        `CHK("sys count", 1'b1, v >= 32'h120 && v <= 32'h140)
    endtask

    // external inputs, only the selected one toggles
    task automatic t_ext;
        for (int s = 1; s <= 2; s++) begin
            ext_sel = s;
            wr(`RCA_OFF_CTRL_SECOND, (s == 1) ? 32'h0000_0000 : 32'h0000_0007);
            wr(`RCA_OFF_SYS_COUNT, 32'h0007_9800);
            wr(`RCA_OFF_OSC_COUNT, 32'h0000_0000);
            conv(32'h0000_0001);
            rd(`RCA_OFF_OSC_COUNT);
            `CHK("ext count", 1'b1, v >= 18 && v <= 22)
        end
        ext_sel = 0;
    endtask

    // pin enables per mode while running, all float once stopped
    task automatic t_pins;
        for (int m = 0; m < 16; m++) begin
            wr(`RCA_OFF_CTRL_SECOND, 32'(m));
            wr(`RCA_OFF_SYS_COUNT, 32'h0007_9900);
            wr(`RCA_OFF_CTRL_FIRST, 32'h0000_0001);
            repeat (10) @(posedge sys_clk);
            #1 `CHK("pin oe", oe_exp[m], pin_oe)
            if (m >= 1 && m <= 4)
                `CHK("pin phase", 1'b1, ^(pin_out & oe_exp[m]))
            `CHK("run", 1'b1, run)
            wr(`RCA_OFF_CTRL_FIRST, 32'h0000_0000);
            repeat (3) @(posedge sys_clk);
            #1 `CHK("oe stop", 6'h00, pin_oe)
            `CHK("run stop", 1'b0, run)
        end
    endtask

    // decade carry mid-count; reserved mode gives no gate end
    task automatic t_carry;
        wr(`RCA_OFF_CTRL_SECOND, 32'h0000_0008);
        wr(`RCA_OFF_SYS_COUNT, 32'h0000_9990);
        wr(`RCA_OFF_CTRL_FIRST, 32'h0000_0003);
        repeat (20) @(posedge sys_clk);
        wr(`RCA_OFF_CTRL_FIRST, 32'h0000_0000);
        rd(`RCA_OFF_SYS_COUNT);
        `CHK("sys carry", 32'h0001_0010, v)
    endtask

    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_ref0();
        t_ref1();
        t_ext();
        t_pins();
        t_carry();
        end_sim();
    end

    // hang guard, well past the expected run length
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule // testbench
